// >>> hdl/sqs_pkg.sv
// Constants for the sequencer stack entry block
`default_nettype none
package sqs_pkg;
    // Entry count and index width
    localparam int          NUM_SLOTS    = 3;
    localparam int          SLOT_W       = 2;
    localparam logic [1:0]  FIRST_SLOT   = 2'h0;
    localparam logic [1:0]  LAST_SLOT    = 2'h2;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_SLOT_10  = 8'h2a;
    localparam logic [7:0]  IDX_SLOT_11  = 8'h2b;
    localparam logic [7:0]  IDX_SLOT_12  = 8'h2c;
    localparam logic [7:0]  IDX_CTRL     = 8'h30;
    localparam logic [7:0]  IDX_STATUS   = 8'h31;
    localparam int          ADDR_W       = 10;
    localparam logic [9:0]  BYTE_SLOT_10 = {IDX_SLOT_10, 2'b00};
    localparam logic [9:0]  BYTE_SLOT_11 = {IDX_SLOT_11, 2'b00};
    localparam logic [9:0]  BYTE_SLOT_12 = {IDX_SLOT_12, 2'b00};
    localparam logic [9:0]  BYTE_CTRL    = {IDX_CTRL, 2'b00};
    localparam logic [9:0]  BYTE_STATUS  = {IDX_STATUS, 2'b00};

    // Entry field positions
    localparam int          F_DIR        = 15;
    localparam int          F_ADDR_HI    = 14;
    localparam int          F_ADDR_LO    = 9;
    localparam int          F_RETURN     = 8;
    localparam int          F_CHB_HI     = 7;
    localparam int          F_CHB_LO     = 4;
    localparam int          F_CHA_HI     = 3;
    localparam int          F_CHA_LO     = 0;

    // Entry reset words and own addresses
    localparam logic [15:0] RST_SLOT_10  = 16'h5400;
    localparam logic [15:0] RST_SLOT_11  = 16'h5600;
    localparam logic [15:0] RST_SLOT_12  = 16'h5800;

    // Control and status bits
    localparam int          C_ENABLE     = 0;
    localparam int          C_RESTART    = 1;
    localparam int          S_SLOT_LO    = 0;
    localparam int          S_SLOT_HI    = 1;
    localparam int          S_BUSY       = 2;
    localparam int          S_ENABLE     = 3;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

    // Sequencer states
    typedef enum logic [0:0] {
        SQS_IDLE    = 1'b0,
        SQS_CONVERT = 1'b1
    } sqs_state_t;
endpackage : sqs_pkg
`default_nettype wire

// >>> hdl/sqs_slot.sv
// One sequencer stack entry register with its access check
`timescale 1ns/100ps
`default_nettype none
module sqs_slot #(
    parameter logic [15:0] RESET_WORD = 16'h0000
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        wr_req,
    input  wire logic [15:0] wr_word,
    output logic             accept,
    output logic [15:0]      word_q
);
    logic [5:0] own_addr;

    // Own address is the reset value of the address field
    assign own_addr = RESET_WORD[sqs_pkg::F_ADDR_HI:sqs_pkg::F_ADDR_LO];

    // Write taken only as a write request naming this entry
    assign accept = wr_req && wr_word[sqs_pkg::F_DIR]
                    && (wr_word[sqs_pkg::F_ADDR_HI:sqs_pkg::F_ADDR_LO] == own_addr);

    // Entry storage, cleared to its documented word
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            word_q <= RESET_WORD;
        end else if (accept) begin
            word_q <= wr_word;
        end
    end
endmodule : sqs_slot
`default_nettype wire

// >>> hdl/sqs_seq_stack.sv
// Sequencer stack entries 10 to 12 with APB access and the entry walker
`timescale 1ns/100ps
`default_nettype none
module sqs_seq_stack (
    input  wire logic        clock,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Converter handshake
    input  wire logic        conv_start,
    input  wire logic        conv_done,
    output logic             sample_q,
    output logic [3:0]       converter_a_channel_pick_q,
    output logic [3:0]       converter_b_channel_pick_q,
    output logic [1:0]       active_slot_q
);
    logic [15:0]             slot_word [sqs_pkg::NUM_SLOTS];
    logic [2:0]              slot_accept;
    logic [2:0]              slot_hit;
    logic [15:0]             wr_word;
    logic                    setup_phase;
    logic                    access_done;
    logic                    wr_any_slot;
    logic                    hit_ctrl;
    logic                    hit_status;
    logic                    hit_slot;
    logic                    mapped;
    logic                    slot_reject;
    logic [31:0]             read_mux;
    logic                    stack_return_bit;
    logic [1:0]              next_slot;
    logic                    enable_q;
    logic                    restart_q;
    logic                    pready_q;
    logic                    pslverr_q;
    logic [31:0]             prdata_q;
    sqs_pkg::sqs_state_t     state_q;
    sqs_pkg::sqs_state_t     state_d;
    logic [1:0]              active_d;

    localparam logic [9:0] SLOT_BYTE [sqs_pkg::NUM_SLOTS] = '{
        sqs_pkg::BYTE_SLOT_10, sqs_pkg::BYTE_SLOT_11, sqs_pkg::BYTE_SLOT_12
    };
    localparam logic [15:0] SLOT_RESET [sqs_pkg::NUM_SLOTS] = '{
        sqs_pkg::RST_SLOT_10, sqs_pkg::RST_SLOT_11, sqs_pkg::RST_SLOT_12
    };

    // Bus phase decode
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready_q;
    assign hit_ctrl    = (paddr == sqs_pkg::BYTE_CTRL);
    assign hit_status  = (paddr == sqs_pkg::BYTE_STATUS);
    assign hit_slot    = |slot_hit;
    assign mapped      = hit_slot || hit_ctrl || hit_status;
    assign wr_any_slot = access_done && pwrite && hit_slot;

    // Byte lanes merge the write over the stored entry
    always_comb begin
        wr_word = 16'h0000;
        for (int i = 0; i < sqs_pkg::NUM_SLOTS; i++) begin
            if (slot_hit[i]) begin
                wr_word = slot_word[i];
            end
        end
        if (pstrb[0]) begin
            wr_word[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
            wr_word[15:8] = pwdata[15:8];
        end
    end

    // One entry register per slot, each at its own address
    for (genvar g = 0; g < sqs_pkg::NUM_SLOTS; g++) begin : g_slot
        assign slot_hit[g] = (paddr == SLOT_BYTE[g]);

        sqs_slot #(
            .RESET_WORD (SLOT_RESET[g])
        ) u_slot (
            .clock   (clock),
            .rst_n   (rst_n),
            .wr_req  (wr_any_slot && slot_hit[g]),
            .wr_word (wr_word),
            .accept  (slot_accept[g]),
            .word_q  (slot_word[g])
        );
    end

    // Write to an entry that is not a write request for it is refused
    assign slot_reject = hit_slot && pwrite && !(|(slot_hit & {
        wr_word[sqs_pkg::F_DIR] && wr_word[sqs_pkg::F_ADDR_HI:sqs_pkg::F_ADDR_LO]
            == SLOT_RESET[2][sqs_pkg::F_ADDR_HI:sqs_pkg::F_ADDR_LO],
        wr_word[sqs_pkg::F_DIR] && wr_word[sqs_pkg::F_ADDR_HI:sqs_pkg::F_ADDR_LO]
            == SLOT_RESET[1][sqs_pkg::F_ADDR_HI:sqs_pkg::F_ADDR_LO],
        wr_word[sqs_pkg::F_DIR] && wr_word[sqs_pkg::F_ADDR_HI:sqs_pkg::F_ADDR_LO]
            == SLOT_RESET[0][sqs_pkg::F_ADDR_HI:sqs_pkg::F_ADDR_LO]
    }));

    // Read data selection
    always_comb begin
        read_mux = sqs_pkg::ZERO_WORD;
        for (int i = 0; i < sqs_pkg::NUM_SLOTS; i++) begin
            if (slot_hit[i]) begin
                read_mux[15:0] = slot_word[i];
            end
        end
        if (hit_ctrl) begin
            read_mux[sqs_pkg::C_ENABLE] = enable_q;
        end
        if (hit_status) begin
            read_mux[sqs_pkg::S_SLOT_HI:sqs_pkg::S_SLOT_LO] = active_slot_q;
            read_mux[sqs_pkg::S_BUSY]   = (state_q == sqs_pkg::SQS_CONVERT);
            read_mux[sqs_pkg::S_ENABLE] = enable_q;
        end
    end

    // Answer one cycle after setup, data and error registered
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setup_phase;
        end
    end

    // Read data and error captured at the setup edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata_q  <= sqs_pkg::ZERO_WORD;
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            prdata_q  <= pwrite ? sqs_pkg::ZERO_WORD : read_mux;
            pslverr_q <= !mapped || (pwrite && hit_status) || slot_reject;
        end else if (access_done) begin
            prdata_q  <= sqs_pkg::ZERO_WORD;
            pslverr_q <= 1'b0;
        end
    end

    assign pready  = pready_q;
    assign prdata  = prdata_q;
    // Error flag straight from its register; refusal already judged at setup
    assign pslverr = pslverr_q;

    // Control register: enable, and one-shot restart
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            enable_q  <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            restart_q <= 1'b0;
            if (access_done && pwrite && hit_ctrl && pstrb[0]) begin
                enable_q  <= pwdata[sqs_pkg::C_ENABLE];
                restart_q <= pwdata[sqs_pkg::C_RESTART];
            end
        end
    end

    // Fields of the active entry
    assign stack_return_bit = slot_word[active_slot_q][sqs_pkg::F_RETURN];

    // Entry after the active one, wrapping past the last
    assign next_slot = (active_slot_q == sqs_pkg::LAST_SLOT)
                       ? sqs_pkg::FIRST_SLOT
                       : active_slot_q + 2'h1;

    // Sequencer next state
    always_comb begin
        state_d  = state_q;
        active_d = active_slot_q;
        case (state_q)
            sqs_pkg::SQS_IDLE: begin
                if (enable_q && conv_start) begin
                    state_d = sqs_pkg::SQS_CONVERT;
                end
            end
            sqs_pkg::SQS_CONVERT: begin
                if (conv_done) begin
                    state_d = sqs_pkg::SQS_IDLE;
                    if (stack_return_bit) begin
                        active_d = sqs_pkg::FIRST_SLOT;
                    end else begin
                        active_d = next_slot;
                    end
                end
            end
            default: begin
                state_d = sqs_pkg::SQS_IDLE;
            end
        endcase
        if (restart_q || !enable_q) begin
            state_d  = sqs_pkg::SQS_IDLE;
            active_d = sqs_pkg::FIRST_SLOT;
        end
    end

    // Sequencer state and active entry
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q       <= sqs_pkg::SQS_IDLE;
            active_slot_q <= sqs_pkg::FIRST_SLOT;
        end else begin
            state_q       <= state_d;
            active_slot_q <= active_d;
        end
    end

    // Channel pair applied together at conversion start
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sample_q                   <= 1'b0;
            converter_a_channel_pick_q <= 4'h0;
            converter_b_channel_pick_q <= 4'h0;
        end else begin
            sample_q <= 1'b0;
            if (state_q == sqs_pkg::SQS_IDLE && state_d == sqs_pkg::SQS_CONVERT) begin
                sample_q <= 1'b1;
                converter_a_channel_pick_q <=
                    slot_word[active_slot_q][sqs_pkg::F_CHA_HI:sqs_pkg::F_CHA_LO];
                converter_b_channel_pick_q <=
                    slot_word[active_slot_q][sqs_pkg::F_CHB_HI:sqs_pkg::F_CHB_LO];
            end
        end
    end
endmodule : sqs_seq_stack
`default_nettype wire

// >>> bench/sqs_checker.sv
// Port assertions for the sequencer stack entries
`timescale 1ns/100ps
`default_nettype none
module sqs_checker (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        conv_start,
    input wire logic        conv_done,
    input wire logic        sample_q,
    input wire logic [3:0]  converter_a_channel_pick_q,
    input wire logic [3:0]  converter_b_channel_pick_q,
    input wire logic [1:0]  active_slot_q
);
    // One clock domain for every check
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    pready_one_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    pready_setup_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error outside access cycle");
    prdata_hi_a: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    sample_pulse_a: assert property (sample_q |=> !sample_q)
        else $error("sample pulse too long");
    sample_cause_a: assert property (sample_q |-> $past(conv_start))
        else $error("sample without start");
    picks_hold_a: assert property (!sample_q |->
        $stable({converter_a_channel_pick_q, converter_b_channel_pick_q}))
        else $error("picks moved without sample");
    slot_move_a: assert property ($changed(active_slot_q) |-> active_slot_q == 2'h0 ||
        ($past(conv_done) && active_slot_q == $past(active_slot_q) + 2'h1))
        else $error("bad entry step");
    // Main scenarios
    cover property (sample_q);
    cover property (pready && pslverr);
    cover property ($changed(active_slot_q) && active_slot_q == 2'h0);
endmodule : sqs_checker
bind sqs_seq_stack sqs_checker sqs_checker_i (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .conv_start(conv_start), .conv_done(conv_done), .sample_q(sample_q),
    .converter_a_channel_pick_q(converter_a_channel_pick_q),
    .converter_b_channel_pick_q(converter_b_channel_pick_q), .active_slot_q(active_slot_q));
`default_nettype wire

// >>> bench/sequencer_stack_entries_bench.sv
// Testbench for the sequencer stack entries
`timescale 1ns/100ps
`default_nettype none
module sequencer_stack_entries_bench;
    typedef struct {logic w; logic [9:0] a; logic [31:0] d; logic e;} sqs_row_t;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hf;
    logic        conv_start = 1'b0;
    logic        conv_done = 1'b0;
    logic        pready;
    logic        pslverr;
    logic        sample_q;
    logic        er;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [3:0]  pick_a;
    logic [3:0]  pick_b;
    logic [1:0]  slot;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    sqs_row_t    rows [11];

    sqs_seq_stack sqs_seq_stack_i (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .conv_start(conv_start),
        .conv_done(conv_done), .sample_q(sample_q), .converter_a_channel_pick_q(pick_a),
        .converter_b_channel_pick_q(pick_b), .active_slot_q(slot));

    // Clock and hang guard
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task report_and_stop;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer, released only after pready is seen
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One conversion on entry s, then the step to entry nx
    task conv(input logic [1:0] s, input logic [3:0] a, input logic [3:0] b,
              input logic [1:0] nx);
        @(posedge clock);
        conv_start <= 1'b1;
        @(posedge clock);
        conv_start <= 1'b0;
        #1;
        check({31'h0, sample_q}, 32'h0000_0001);
        check({22'h0, slot, pick_b, pick_a}, {22'h0, s, b, a});
        @(posedge clock);
        conv_done <= 1'b1;
        @(posedge clock);
        conv_done <= 1'b0;
        #1;
        check({30'h0, slot}, {30'h0, nx});
    endtask : conv

    // Register rows, walk of the stack, then a second reset
    initial begin
        rows[0] = '{1'b1, sqs_pkg::BYTE_SLOT_10, 32'h0000_d435, 1'b0};
        rows[1] = '{1'b0, sqs_pkg::BYTE_SLOT_10, 32'h0000_d435, 1'b0};
        rows[2] = '{1'b1, sqs_pkg::BYTE_SLOT_11, 32'h0000_d769, 1'b0};
        rows[3] = '{1'b1, sqs_pkg::BYTE_SLOT_12, 32'h0000_d8c2, 1'b0};
        rows[4] = '{1'b1, sqs_pkg::BYTE_SLOT_11, 32'h0000_d4ff, 1'b1};
        rows[5] = '{1'b0, sqs_pkg::BYTE_SLOT_11, 32'h0000_d769, 1'b0};
        rows[6] = '{1'b1, sqs_pkg::BYTE_SLOT_12, 32'h0000_58aa, 1'b1};
        rows[7] = '{1'b0, sqs_pkg::BYTE_SLOT_12, 32'h0000_d8c2, 1'b0};
        rows[8] = '{1'b0, 10'h000, 32'h0000_0000, 1'b1};
        rows[9] = '{1'b1, sqs_pkg::BYTE_STATUS, 32'h0000_0000, 1'b1};
        rows[10] = '{1'b1, sqs_pkg::BYTE_CTRL, 32'h0000_0001, 1'b0};
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
            check({31'h0, er}, {31'h0, rows[i].e});
            if (!rows[i].w)
                check(rd, rows[i].d);
        end
        // Low byte lane only: upper byte of entry 12 kept
        pstrb <= 4'h1;
        apb(1'b1, sqs_pkg::BYTE_SLOT_12, 32'h0000_00c4, rd, er);
        pstrb <= 4'hf;
        check({31'h0, er}, 32'h0000_0000);
        apb(1'b0, sqs_pkg::BYTE_SLOT_12, 32'h0000_0000, rd, er);
        check(rd, 32'h0000_d8c4);
        conv(2'h0, 4'h5, 4'h3, 2'h1);
        // Status: entry 11 active, idle, enabled
        apb(1'b0, sqs_pkg::BYTE_STATUS, 32'h0000_0000, rd, er);
        check(rd, 32'h0000_0009);
        // Restart sends the walk back to entry 10
        apb(1'b1, sqs_pkg::BYTE_CTRL, 32'h0000_0003, rd, er);
        @(posedge clock);
        #1;
        check({30'h0, slot}, 32'h0000_0000);
        conv(2'h0, 4'h5, 4'h3, 2'h1);
        conv(2'h1, 4'h9, 4'h6, 2'h0);
        apb(1'b1, sqs_pkg::BYTE_SLOT_11, 32'h0000_d669, rd, er);
        check({31'h0, er}, 32'h0000_0000);
        conv(2'h0, 4'h5, 4'h3, 2'h1);
        conv(2'h1, 4'h9, 4'h6, 2'h2);
        conv(2'h2, 4'h4, 4'hc, 2'h0);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        conv_start <= 1'b1;
        @(posedge clock);
        conv_start <= 1'b0;
        @(posedge clock);
        #1;
        check({23'h0, sample_q, pick_b, pick_a}, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, sqs_pkg::BYTE_SLOT_10 + 10'(4 * k), 32'h0000_0000, rd, er);
            check(rd, 32'h0000_5400 + 32'(k * 512));
        end
        report_and_stop();
    end
endmodule : sequencer_stack_entries_bench
`default_nettype wire
